// ### bench/switch_global_frame_aging_control_bench.sv
// Self-checking bench for the switch global frame and aging control block.
`timescale 1ns/1ps
`include "sgfa_params.svh"

module switch_global_frame_aging_control_bench;
  import sgfa_pkg::*;
  localparam logic [35:0] FC = 36'h0_0000_0014;
  localparam logic [35:0] NC = 36'h0_0000_0032;
  localparam logic [7:0]  A0 = 8'(`SGFA_IDX_CTRL_ZERO * `SGFA_ADDR_SCALE);
  localparam logic [7:0]  A1 = 8'(`SGFA_IDX_CTRL_ONE * `SGFA_ADDR_SCALE);
  localparam logic [1:0]  OK = `SGFA_RESP_OKAY;
  localparam logic [1:0]  SE = `SGFA_RESP_SLVERR;
  localparam logic [15:0] CFG [6] = '{16'h0004, 16'h020c, 16'h0044, 16'h024c, 16'h0084,
                                      16'h00c8};
  logic             clk = 1'b0, rst_b = 1'b0, strap = 1'b1, an_tx = 1'b1, an_rx = 1'b1;
  logic [7:0]       awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]      wdata = 32'h0000_0000;
  logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic             rready = 1'b0, fdone = 1'b0, sdone = 1'b0;
  logic [3:0]       link = 4'hf;
  logic [3:0]       wstrb = 4'hf;
  sgfa_frame_type   finfo = '0;
  logic             awready, wready, bvalid, arready, rvalid, astart, flush, afast;
  logic             txfc, rxfc, longen;
  logic [1:0]       bresp, rresp;
  logic [31:0]      rdata;
  sgfa_verdict_type verdict;
  int               fails = 0, cmp_count = 0, seed = 32'h40f7, n;
  logic [1:0]       bq[$];
  logic [33:0]      rq[$];
  logic             vq[$];

  sgfa_top #(.FAST_CYCLES(FC), .NORMAL_CYCLES(NC)) DUT (
    .core_clk_i(clk), .rst_b_i(rst_b), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .flow_control_strap_pin_i(strap), .port_link_up_i(link),
    .an_tx_pause_i(an_tx), .an_rx_pause_i(an_rx), .frame_done_i(fdone),
    .frame_info_i(finfo), .age_scan_done_i(sdone), .verdict_o(verdict),
    .age_scan_start_o(astart), .flush_all_o(flush), .aging_fast_o(afast),
    .tx_fc_en_o(txfc), .rx_fc_en_o(rxfc), .long_frame_enable_o(longen));

  // ----------------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------------
  always #2.5 clk = ~clk;

  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Address and data are offered together and each is dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bq.push_back(r);
    do
    begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid && n < 100);
    if (!bvalid) fails++;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rq.push_back(e);
    do
    begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid && n < 100);
    if (!rvalid) fails++;
    rready <= 1'b0;
  endtask

  // One random frame; the verdict is worked out here from the filter rules.
  task automatic frame(input logic [7:0] c0, input logic [7:0] c1);
    sgfa_frame_type f;
    logic           ps, lb, tl;
    f.dest_addr = ($random(seed) & 1) ? `SGFA_PAUSE_DA : 48'({$random(seed), $random(seed)});
    case ($unsigned($random(seed)) % 4)
      0: f.type_len = `SGFA_PAUSE_TYPE;
      1: f.type_len = 16'h05dc;
      2: f.type_len = 16'($unsigned($random(seed)) % 1500);
      default: f.type_len = 16'h0800;
    endcase
    f.payload_len = ($random(seed) & 1) ? f.type_len : 16'($random(seed));
    f.frame_len = 16'(1500 + $unsigned($random(seed)) % 600);
    f.errored = ($random(seed) & 7) == 0;
    f.flow_ctrl = 1'($random(seed));
    ps = c0[1] ? (f.type_len == `SGFA_PAUSE_TYPE || f.dest_addr == `SGFA_PAUSE_DA) :
         f.flow_ctrl;
    lb = c1[3] && f.type_len < `SGFA_LEN_LIMIT && f.type_len != f.payload_len;
    tl = f.frame_len > (c1[6] ? `SGFA_LONG_MAX : `SGFA_STD_MAX);
    vq.push_back(!c1[7] && (f.errored || ps || lb || tl));
    @(posedge clk);
    finfo <= f;
    fdone <= 1'b1;
  endtask

  // Time-ordered results are matched against the oldest expectation noted.
  always @(posedge clk)
  begin
    if (bvalid && bready) chk("bresp", bresp, bq.size() ? bq.pop_front() : 2'bxx);
    if (rvalid && rready) chk("read", {rresp, rdata}, rq.size() ? rq.pop_front() : 'x);
    if (verdict.valid) chk("verdict", verdict.drop, vq.size() ? vq.pop_front() : 1'bx);
  end

  // Gap between two aging starts, with one cycle of slack for the restart.
  task automatic period(input logic [35:0] p);
    n = 0;
    while (!astart && n < 200) @(posedge clk) n++;
    n = 0;
    do @(posedge clk) n++; while (!astart && n < 200);
    chk("gap", n >= p && n <= p + 1, 1'b1);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    rd(A1, {OK, 32'h0000_0034});
    rd(A0, {OK, 32'h0000_0000});
    chk("txfc", txfc, 1'b0);
    wr(A1, 8'h14, OK);
    repeat (2) @(posedge clk);
    chk("txfc", txfc, 1'b1);
    chk("rxfc", rxfc, 1'b0);
    wr(A1, 8'h24, OK);
    an_tx <= 1'b0;
    repeat (2) @(posedge clk);
    chk("txfc", txfc, 1'b0);
    chk("rxfc", rxfc, 1'b1);
    wr(8'h10, 8'hff, SE);
    rd(8'h10, {SE, 32'h0000_0000});
    wr(A0, 8'hff, OK);
    rd(A0, {OK, 32'h0000_0003});
    // A write with its low byte lane off is answered but changes nothing.
    wstrb <= 4'h0;
    wr(A0, 8'h00, OK);
    wstrb <= 4'hf;
    rd(A0, {OK, 32'h0000_0003});
    foreach (CFG[i])
    begin
      wr(A0, CFG[i][15:8], OK);
      wr(A1, CFG[i][7:0], OK);
      for (int k = 0; k < 16; k++) frame(CFG[i][15:8], CFG[i][7:0]);
      @(posedge clk);
      fdone <= 1'b0;
      chk("long", longen, CFG[i][6]);
    end
    wr(A0, 8'h00, OK);
    wr(A1, 8'h06, OK);
    @(posedge clk);
    chk("afast", afast, 1'b1);
    period(FC);
    wr(A1, 8'h04, OK);
    period(NC);
    wr(A1, 8'h00, OK);
    n = 0;
    repeat (150) @(posedge clk) n += astart;
    chk("aging off", n, 0);
    wr(A1, 8'h04, OK);
    wr(A0, 8'h01, OK);
    link <= 4'hb;
    n = 0;
    do @(posedge clk) n++; while (!flush && n < 12);
    chk("flush", flush, 1'b1);
    chk("start", astart, 1'b1);
    repeat (3) @(posedge clk);
    chk("afast", afast, 1'b1);
    sdone <= 1'b1;
    @(posedge clk);
    sdone <= 1'b0;
    link <= 4'hf;
    repeat (3) @(posedge clk);
    chk("afast", afast, 1'b0);
    period(NC);
    rst_b <= 1'b0;
    strap <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    rd(A1, {OK, 32'h0000_0004});
    repeat (4) @(posedge clk);
    summarize();
  end

  // A hang is cut short well past the expected run length.
  initial
  begin
    #(5 * 40000);
    fails++;
    summarize();
  end
endmodule

// ### hdl/sgfa_params.svh
// Constants of the switch global frame and aging control block.
`ifndef SGFA_PARAMS_SVH
`define SGFA_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map: indexes and the byte address rule.
// ----------------------------------------------------------------------
`define SGFA_IDX_CTRL_ZERO   8'h02
`define SGFA_IDX_CTRL_ONE    8'h03
`define SGFA_ADDR_SCALE      8'h04

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define SGFA_C0_LINK_AGE     0
`define SGFA_C0_CONF_DROP    1
`define SGFA_C1_FAST_AGE     1
`define SGFA_C1_AGING_EN     2
`define SGFA_C1_LEN_CHECK    3
`define SGFA_C1_RX_FC_DIS    4
`define SGFA_C1_TX_FC_DIS    5
`define SGFA_C1_LONG_FRAME   6
`define SGFA_C1_PASS_ALL     7

// ----------------------------------------------------------------------
// Reset values; the flow control bits come from the strap instead.
// ----------------------------------------------------------------------
`define SGFA_C0_RESET        8'h00
`define SGFA_C1_RESET        8'h04

// ----------------------------------------------------------------------
// Frame filter constants.
// ----------------------------------------------------------------------
`define SGFA_PAUSE_TYPE      16'h8808
`define SGFA_PAUSE_DA        48'h0180_c200_0001
`define SGFA_LEN_LIMIT       16'h05dc
`define SGFA_LONG_MAX        16'h0800
`define SGFA_STD_MAX         16'h05ee

// ----------------------------------------------------------------------
// Timing: times in their own unit, cycles derived from the clock.
// ----------------------------------------------------------------------
`define SGFA_CLK_PERIOD_PS   64'h0000_0000_0000_1388
`define SGFA_FAST_AGE_US     64'h0000_0000_0000_0320
`define SGFA_NORMAL_AGE_S    64'h0000_0000_0000_012c
`define SGFA_FAST_CYCLES     ((`SGFA_FAST_AGE_US * 64'h0000_0000_000f_4240) / `SGFA_CLK_PERIOD_PS)
`define SGFA_NORMAL_CYCLES   ((`SGFA_NORMAL_AGE_S * 64'h0000_00e8_d4a5_1000) / `SGFA_CLK_PERIOD_PS)

// ----------------------------------------------------------------------
// Bus answers.
// ----------------------------------------------------------------------
`define SGFA_RESP_OKAY       2'h0
`define SGFA_RESP_SLVERR     2'h2

`endif

// ### hdl/sgfa_pkg.sv
// Types shared by the switch global frame and aging control block.
package sgfa_pkg;

  // Summary of one received frame, handed over by the frame parser.
  typedef struct packed {
    logic [47:0] dest_addr;
    logic [15:0] type_len;
    logic [15:0] frame_len;
    logic [15:0] payload_len;
    logic        errored;
    logic        flow_ctrl;
  } sgfa_frame_type;

  // Drop verdict for one frame.
  typedef struct packed {
    logic valid;
    logic drop;
  } sgfa_verdict_type;

  // Aging engine state, one-hot.
  typedef enum logic [1:0] {
    SGFA_AGE_NORMAL   = 2'b01,
    SGFA_AGE_LINKFAST = 2'b10
  } sgfa_age_state_type;

endpackage

// ### hdl/sgfa_top.sv
// Global frame filtering, aging and flow control configuration with AXI4-Lite access.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "sgfa_params.svh"

module sgfa_top
  import sgfa_pkg::*;
#(
  parameter int          NUM_PORTS     = 4,
  parameter int          ADDR_W        = 8,
  parameter logic [35:0] FAST_CYCLES   = 36'(`SGFA_FAST_CYCLES),
  parameter logic [35:0] NORMAL_CYCLES = 36'(`SGFA_NORMAL_CYCLES)
)
(
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_b_i,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr_i,
  input  wire logic                 s_axi_awvalid_i,
  output logic                      s_axi_awready_o,
  input  wire logic [31:0]          s_axi_wdata_i,
  input  wire logic [3:0]           s_axi_wstrb_i,
  input  wire logic                 s_axi_wvalid_i,
  output logic                      s_axi_wready_o,
  output logic [1:0]                s_axi_bresp_o,
  output logic                      s_axi_bvalid_o,
  input  wire logic                 s_axi_bready_i,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr_i,
  input  wire logic                 s_axi_arvalid_i,
  output logic                      s_axi_arready_o,
  output logic [31:0]               s_axi_rdata_o,
  output logic [1:0]                s_axi_rresp_o,
  output logic                      s_axi_rvalid_o,
  input  wire logic                 s_axi_rready_i,
  input  wire logic                 flow_control_strap_pin_i,
  input  wire logic [NUM_PORTS-1:0] port_link_up_i,
  input  wire logic                 an_tx_pause_i,
  input  wire logic                 an_rx_pause_i,
  input  wire logic                 frame_done_i,
  input  wire sgfa_frame_type       frame_info_i,
  input  wire logic                 age_scan_done_i,
  output sgfa_verdict_type          verdict_o,
  output logic                      age_scan_start_o,
  output logic                      flush_all_o,
  output logic                      aging_fast_o,
  output logic                      tx_fc_en_o,
  output logic                      rx_fc_en_o,
  output logic                      long_frame_enable_o
);

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Byte address of a register index; both decoders use it.
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = ADDR_W'(idx * `SGFA_ADDR_SCALE);
  endfunction

  // ----------------------------------------------------------------------
  // Registers and bus state
  // ----------------------------------------------------------------------
  logic [7:0]          ctrl_zero_r;
  logic [7:0]          ctrl_one_r;
  logic [ADDR_W-1:0]   awaddr_r;
  logic [31:0]         wdata_r;
  logic [3:0]          wstrb_r;
  logic                awready_r;
  logic                wready_r;
  logic                bvalid_r;
  logic [1:0]          bresp_r;
  logic                arready_r;
  logic                rvalid_r;
  logic [1:0]          rresp_r;
  logic [31:0]         rdata_r;
  logic                wr_commit;
  logic                strap_s1;
  logic                strap_s2;
  logic                strap_s3;
  logic                strap_loaded_r;

  assign wr_commit = !awready_r && !wready_r && !bvalid_r;

  // Write address and data are taken independently and held until the response is taken.
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
    end
    else
    begin
      if (s_axi_awvalid_i && awready_r)
      begin
        awaddr_r  <= s_axi_awaddr_i;
        awready_r <= 1'b0;
      end
      else if (bvalid_r && s_axi_bready_i)
        awready_r <= 1'b1;
      if (s_axi_wvalid_i && wready_r)
      begin
        wdata_r  <= s_axi_wdata_i;
        wstrb_r  <= s_axi_wstrb_i;
        wready_r <= 1'b0;
      end
      else if (bvalid_r && s_axi_bready_i)
        wready_r <= 1'b1;
    end
  end

  // Write response; an unmapped address answers SLVERR and changes nothing.
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= `SGFA_RESP_OKAY;
    end
    else if (wr_commit)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= (awaddr_r == reg_addr(`SGFA_IDX_CTRL_ZERO) ||
                   awaddr_r == reg_addr(`SGFA_IDX_CTRL_ONE)) ? `SGFA_RESP_OKAY : `SGFA_RESP_SLVERR;
    end
    else if (s_axi_bready_i)
      bvalid_r <= 1'b0;
  end

  // The strap is a pin: it is sampled without reset so its level is ready at the release.
  always_ff @(posedge core_clk_i)
  begin
    strap_s1 <= flow_control_strap_pin_i;
    strap_s2 <= strap_s1;
    strap_s3 <= strap_s2;
  end

  // Control registers; the strap is loaded once, in the first cycle after reset in which stages two and three agree.
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl_zero_r    <= `SGFA_C0_RESET;
      ctrl_one_r     <= `SGFA_C1_RESET;
      strap_loaded_r <= 1'b0;
    end
    else
    begin
      if (!strap_loaded_r)
      begin
        // The level counts only once stages two and three agree.
        if (strap_s2 == strap_s3)
        begin
          strap_loaded_r                 <= 1'b1;
          ctrl_one_r[`SGFA_C1_TX_FC_DIS] <= strap_s3;
          ctrl_one_r[`SGFA_C1_RX_FC_DIS] <= strap_s3;
        end
      end
      else if (wr_commit && wstrb_r[0])
      begin
        if (awaddr_r == reg_addr(`SGFA_IDX_CTRL_ZERO))
          ctrl_zero_r[1:0] <= wdata_r[1:0];
        if (awaddr_r == reg_addr(`SGFA_IDX_CTRL_ONE))
          ctrl_one_r[7:1]  <= wdata_r[7:1];
      end
    end
  end

  // Read channel; data is captured with the address so rdata stands with rvalid.
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= `SGFA_RESP_OKAY;
      rdata_r   <= '0;
    end
    else if (s_axi_arvalid_i && arready_r)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= `SGFA_RESP_OKAY;
      if (s_axi_araddr_i == reg_addr(`SGFA_IDX_CTRL_ZERO))
        rdata_r <= {24'h00_0000, 6'h00, ctrl_zero_r[1:0]};
      else if (s_axi_araddr_i == reg_addr(`SGFA_IDX_CTRL_ONE))
        rdata_r <= {24'h00_0000, ctrl_one_r[7:1], 1'b0};
      else
      begin
        rdata_r <= '0;
        rresp_r <= `SGFA_RESP_SLVERR;
      end
    end
    else if (rvalid_r && s_axi_rready_i)
    begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o  = wready_r;
  assign s_axi_bvalid_o  = bvalid_r;
  assign s_axi_bresp_o   = bresp_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o  = rvalid_r;
  assign s_axi_rresp_o   = rresp_r;
  assign s_axi_rdata_o   = rdata_r;

  // ----------------------------------------------------------------------
  // Frame filter
  // ----------------------------------------------------------------------
  logic pause_hit;
  logic len_bad;
  logic too_long;

  // Conformance mode swaps the pause test from the parser's own flag to a fixed match.
  assign pause_hit = ctrl_zero_r[`SGFA_C0_CONF_DROP] ?
                     (frame_info_i.type_len == `SGFA_PAUSE_TYPE ||
                      frame_info_i.dest_addr == `SGFA_PAUSE_DA) :
                     frame_info_i.flow_ctrl;
  assign len_bad   = ctrl_one_r[`SGFA_C1_LEN_CHECK] &&
                     frame_info_i.type_len < `SGFA_LEN_LIMIT &&
                     frame_info_i.type_len != frame_info_i.payload_len;
  assign too_long  = frame_info_i.frame_len >
                     (ctrl_one_r[`SGFA_C1_LONG_FRAME] ? `SGFA_LONG_MAX : `SGFA_STD_MAX);

  // Pass-all overrides every drop reason, so a debug capture sees the bad frames too.
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      verdict_o <= '0;
    else
    begin
      verdict_o.valid <= frame_done_i;
      verdict_o.drop  <= frame_done_i && !ctrl_one_r[`SGFA_C1_PASS_ALL] &&
                         (frame_info_i.errored || pause_hit || len_bad || too_long);
    end
  end

  // ----------------------------------------------------------------------
  // Link watch: three flops per port, a change counts once stages two and three agree
  // ----------------------------------------------------------------------
  logic [NUM_PORTS-1:0] link_s1;
  logic [NUM_PORTS-1:0] link_s2;
  logic [NUM_PORTS-1:0] link_s3;
  logic [NUM_PORTS-1:0] link_stable_r;
  logic [NUM_PORTS-1:0] link_next;
  logic                 link_lost;

  assign link_next = (link_s2 & link_s3) | (link_stable_r & (link_s2 ^ link_s3));
  assign link_lost = |(link_stable_r & ~link_next);

  // Ports start as down so a link coming up at power-on never looks like an unplug.
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      link_s1       <= '0;
      link_s2       <= '0;
      link_s3       <= '0;
      link_stable_r <= '0;
    end
    else
    begin
      link_s1       <= port_link_up_i;
      link_s2       <= link_s1;
      link_s3       <= link_s2;
      link_stable_r <= link_next;
    end
  end

  // ----------------------------------------------------------------------
  // Aging engine
  // ----------------------------------------------------------------------
  sgfa_age_state_type age_state_r;
  logic [35:0]        age_cnt_r;
  logic [35:0]        period;
  logic               period_end;
  logic               link_trig;

  assign period     = ctrl_one_r[`SGFA_C1_FAST_AGE] ? FAST_CYCLES : NORMAL_CYCLES;
  assign period_end = age_cnt_r >= period - 36'h0_0000_0001;
  assign link_trig  = link_lost && ctrl_zero_r[`SGFA_C0_LINK_AGE];

  // One counter serves both the period and the fast-pass deadline.
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      age_state_r      <= SGFA_AGE_NORMAL;
      age_cnt_r        <= '0;
      age_scan_start_o <= 1'b0;
      flush_all_o      <= 1'b0;
    end
    else
    begin
      age_scan_start_o <= 1'b0;
      flush_all_o      <= 1'b0;
      case (age_state_r)
        SGFA_AGE_NORMAL:
        begin
          if (link_trig)
          begin
            age_state_r      <= SGFA_AGE_LINKFAST;
            age_cnt_r        <= '0;
            age_scan_start_o <= 1'b1;
            flush_all_o      <= 1'b1;
          end
          else if (!ctrl_one_r[`SGFA_C1_AGING_EN])
            age_cnt_r <= '0;
          else if (period_end)
          begin
            age_cnt_r        <= '0;
            age_scan_start_o <= 1'b1;
          end
          else
            age_cnt_r <= age_cnt_r + 36'h0_0000_0001;
        end
        SGFA_AGE_LINKFAST:
        begin
          // The pass ends on done or at the fast deadline, whichever comes first.
          if (age_scan_done_i || age_cnt_r >= FAST_CYCLES - 36'h0_0000_0001)
          begin
            age_state_r <= SGFA_AGE_NORMAL;
            age_cnt_r   <= '0;
          end
          else
            age_cnt_r <= age_cnt_r + 36'h0_0000_0001;
        end
        default:
        begin
          age_state_r <= SGFA_AGE_NORMAL;
          age_cnt_r   <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Flow control and configuration outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tx_fc_en_o          <= 1'b0;
      rx_fc_en_o          <= 1'b0;
      long_frame_enable_o <= 1'b0;
      aging_fast_o        <= 1'b0;
    end
    else
    begin
      tx_fc_en_o          <= an_tx_pause_i && !ctrl_one_r[`SGFA_C1_TX_FC_DIS];
      rx_fc_en_o          <= an_rx_pause_i && !ctrl_one_r[`SGFA_C1_RX_FC_DIS];
      long_frame_enable_o <= ctrl_one_r[`SGFA_C1_LONG_FRAME];
      aging_fast_o        <= ctrl_one_r[`SGFA_C1_FAST_AGE] ||
                             age_state_r == SGFA_AGE_LINKFAST;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_conf_pause_drop: assert property (
    frame_done_i && ctrl_zero_r[`SGFA_C0_CONF_DROP] && !ctrl_one_r[`SGFA_C1_PASS_ALL] &&
    frame_info_i.type_len == `SGFA_PAUSE_TYPE |=> verdict_o.valid && verdict_o.drop)
    else $error("Conformance pause frame was not dropped.");

  chk_std_pause_drop: assert property (
    frame_done_i && !ctrl_zero_r[`SGFA_C0_CONF_DROP] && !frame_info_i.flow_ctrl &&
    !frame_info_i.errored && !len_bad && !too_long |=> !verdict_o.drop)
    else $error("Frame dropped without a reason.");

  chk_link_pass_start: assert property (
    age_state_r == SGFA_AGE_NORMAL && link_trig |=> age_scan_start_o && flush_all_o &&
    age_state_r == SGFA_AGE_LINKFAST)
    else $error("Link loss did not start a fast pass.");

  chk_link_pass_bound: assert property (
    age_state_r == SGFA_AGE_LINKFAST |-> age_cnt_r < FAST_CYCLES)
    else $error("Fast pass ran past its deadline.");

  chk_pass_all_fwd: assert property (
    ctrl_one_r[`SGFA_C1_PASS_ALL] |=> !verdict_o.drop)
    else $error("Frame dropped in pass-all mode.");

  chk_tx_fc_off: assert property (
    ctrl_one_r[`SGFA_C1_TX_FC_DIS] |=> !tx_fc_en_o)
    else $error("Transmit flow control on while disabled.");

  chk_rx_fc_follow: assert property (
    !ctrl_one_r[`SGFA_C1_RX_FC_DIS] && $stable(ctrl_one_r) |=> rx_fc_en_o == $past(an_rx_pause_i))
    else $error("Receive flow control does not follow negotiation.");

  chk_strap_load: assert property (
    $rose(strap_loaded_r) |-> ctrl_one_r[`SGFA_C1_TX_FC_DIS] == $past(strap_s3) &&
    ctrl_one_r[`SGFA_C1_RX_FC_DIS] == $past(strap_s3))
    else $error("Strap level not loaded into flow control bits.");

  chk_aging_off: assert property (
    !ctrl_one_r[`SGFA_C1_AGING_EN] && !link_trig && age_state_r == SGFA_AGE_NORMAL
    |=> !age_scan_start_o)
    else $error("Aging pass started while aging disabled.");

  chk_len_check: assert property (
    frame_done_i && len_bad && !ctrl_one_r[`SGFA_C1_PASS_ALL] |=> verdict_o.drop)
    else $error("Length mismatch frame not dropped.");

endmodule
